// ---- dv/swa_access_props.sv ----
// port checker for the table access controller
`timescale 1ns/100ps
`default_nettype none
module swa_access_props (
    // clock and reset
    input wire logic         clk_sys,
    input wire logic         nrst,
    // register port
    input wire logic [15:0]  reg_addr,
    input wire logic         reg_wr,
    input wire logic         reg_rd,
    input wire logic [7:0]   reg_wdata,
    input wire logic [7:0]   reg_rdata_ff,
    // lookup engine port
    input wire logic         alu_req_ff,
    input wire logic [1:0]   alu_op_ff,
    input wire logic [11:0]  alu_index_ff,
    input wire logic [127:0] alu_wdata_ff,
    input wire logic         alu_srch_ready_ff,
    input wire logic         alu_ack,
    input wire logic [127:0] alu_rdata,
    input wire logic         alu_entry_valid,
    input wire logic         alu_srch_done,
    input wire logic [13:0]  alu_count
);
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!nrst);
    a_ack_drops_req: assert property (
        alu_req_ff && alu_ack |=> !alu_req_ff) else $error("request held after ack");
    a_req_holds_op: assert property (
        alu_req_ff && !alu_ack && !alu_srch_done |=> alu_req_ff && $stable(alu_op_ff))
        else $error("request or op moved early");
    a_op_not_nop: assert property (
        alu_req_ff |-> alu_op_ff != 2'b00) else $error("request with no operation");
    a_read_loads_word: assert property (
        alu_req_ff && alu_ack && alu_op_ff == 2'b10 ##2 reg_rd && reg_addr == 16'h0420
        |=> reg_rdata_ff == $past(alu_rdata[7:0], 3)) else $error("read result not in word one");
    a_take_entry: assert property (
        alu_srch_ready_ff && alu_entry_valid |=> !alu_srch_ready_ff) else $error("entry not taken");
    a_ready_flags: assert property (
        alu_srch_ready_ff && alu_entry_valid ##2 reg_rd && reg_addr == 16'h0418
        |=> reg_rdata_ff[6] && reg_rdata_ff[5]) else $error("ready flags low");
    a_count_shown: assert property (
        alu_srch_done ##2 reg_rd && reg_addr == 16'h041A
        |=> reg_rdata_ff == $past(alu_count[7:0], 3)) else $error("count not shown");
    a_unmapped_zero: assert property (
        reg_rd && reg_addr == 16'h0500 |=> reg_rdata_ff == 8'h00) else $error("unmapped read nonzero");
endmodule
`default_nettype wire

// ---- dv/testbench.sv ----
// self-checking bench for the table access controller
`timescale 1ns/100ps
`default_nettype none
module testbench;
    logic         clk_sys, nrst, reg_wr, reg_rd, alu_ack, alu_entry_valid, alu_srch_done;
    logic [15:0]  reg_addr;
    logic [7:0]   reg_wdata, reg_rdata_ff;
    logic         alu_req_ff, alu_srch_ready_ff;
    logic [1:0]   alu_op_ff;
    logic [11:0]  alu_index_ff;
    logic [127:0] alu_wdata_ff, alu_rdata;
    logic [13:0]  alu_count;
    int           miscompares = 0;
    int           checked = 0;
    swa_access_ctrl dut (.clk_sys, .nrst, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata_ff,
        .alu_req_ff, .alu_op_ff, .alu_index_ff, .alu_wdata_ff, .alu_srch_ready_ff, .alu_ack,
        .alu_rdata, .alu_entry_valid, .alu_srch_done, .alu_count);
    initial begin
        clk_sys = 1'b0;
        forever #12.5 clk_sys = ~clk_sys;
    end
    task automatic test_done();
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // bytes go in at the falling edge, one strobe cycle each
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(negedge clk_sys);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(negedge clk_sys);
        reg_wr = 1'b0;
    endtask
    task automatic wr32(input logic [15:0] a, input logic [31:0] d);
        for (int i = 0; i < 4; i++) begin
            wr(a + 16'(i), d[8*i +: 8]);
        end
    endtask
    task automatic rd(input logic [15:0] a, output logic [7:0] d);
        @(negedge clk_sys);
        reg_addr = a;
        reg_rd = 1'b1;
        @(negedge clk_sys);
        reg_rd = 1'b0;
        d = reg_rdata_ff;
    endtask
    task automatic rdc(input logic [15:0] a, input logic [7:0] e);
        logic [7:0] d;
        rd(a, d);
        chk(d, e);
    endtask
    // answer one engine request; a request that never comes ends the run
    task automatic serve(input logic [1:0] op, input logic [127:0] rdat);
        int n;
        n = 0;
        while (alu_req_ff !== 1'b1 && n < 20) begin
            @(negedge clk_sys);
            n++;
        end
        if (alu_req_ff !== 1'b1) begin
            miscompares++;
            test_done();
        end
        chk(alu_op_ff, op);
        alu_rdata = rdat;
        alu_ack = 1'b1;
        @(negedge clk_sys);
        alu_ack = 1'b0;
    endtask
    // fixed-table start, then poll until go drops by itself
    task automatic fx(input logic [7:0] ctl);
        logic [7:0] d;
        wr(16'h041C, ctl | 8'h80);
        for (int i = 0; i < 10; i++) begin
            rd(16'h041C, d);
            if (d[7] === 1'b0) begin
                chk(d, ctl);
                return;
            end
        end
        miscompares++;
        test_done();
    endtask
    task automatic s_idle();
        rdc(16'h0418, 8'h00);
        rdc(16'h041A, 8'h00);
        rdc(16'h0500, 8'h00);
    endtask
    task automatic s_lookup();
        wr32(16'h0414, 32'h0000_0ABC);
        wr32(16'h0420, 32'h1122_3344);
        wr(16'h0418, 8'h85);
        rdc(16'h0418, 8'h85);
        chk(alu_index_ff, 12'hABC);
        chk(alu_wdata_ff[31:0], 32'h1122_3344);
        serve(2'b01, '0);
        rdc(16'h0418, 8'h05);
        wr(16'h0418, 8'h80);
        repeat (3) @(negedge clk_sys);
        chk(alu_req_ff, 1'b0);
        wr(16'h0418, 8'h86);
        serve(2'b10, {32'hA4A3_A2A1, 32'hB4B3_B2B1, 32'hC4C3_C2C1, 32'hD4D3_D2D1});
        rdc(16'h0420, 8'hD1);
        rdc(16'h0426, 8'hC3);
    endtask
    task automatic s_search();
        wr(16'h0412, 8'h05);
        wr(16'h0418, 8'h83);
        serve(2'b11, '0);
        chk(alu_index_ff, 12'hAB9);
        chk(alu_srch_ready_ff, 1'b1);
        alu_rdata = {32'h5A00_0000, 96'h0};
        alu_entry_valid = 1'b1;
        @(negedge clk_sys);
        alu_entry_valid = 1'b0;
        rdc(16'h0418, 8'hE3);
        rdc(16'h042F, 8'h5A);
        rdc(16'h0418, 8'h83);
        wr(16'h0418, 8'h00);
        rdc(16'h0418, 8'h83);
        alu_count = 14'h1234;
        alu_srch_done = 1'b1;
        @(negedge clk_sys);
        alu_srch_done = 1'b0;
        rdc(16'h041A, 8'h34);
        rdc(16'h041B, 8'h12);
        rdc(16'h0418, 8'h23);
    endtask
    task automatic s_fixed();
        wr32(16'h0424, 32'hCAFE_0001);
        wr(16'h041E, 8'h25);
        fx(8'h02);
        wr32(16'h0424, 32'h0);
        wr32(16'h0420, 32'h77);
        fx(8'h03);
        rdc(16'h0427, 8'hCA);
        rdc(16'h0420, 8'h77);
        wr(16'h041E, 8'h13);
        fx(8'h00);
        wr32(16'h0420, 32'h0);
        wr(16'h041E, 8'h03);
        fx(8'h01);
        rdc(16'h0420, 8'h77);
    endtask
    initial begin
        {nrst, reg_wr, reg_rd, alu_ack, alu_entry_valid, alu_srch_done} = '0;
        reg_addr = '0;
        reg_wdata = '0;
        alu_rdata = '0;
        alu_count = '0;
        repeat (10) @(negedge clk_sys);
        nrst = 1'b1;
        s_idle();
        s_lookup();
        s_search();
        s_fixed();
        test_done();
    end
endmodule
bind swa_access_ctrl swa_access_props u_props (.clk_sys, .nrst, .reg_addr, .reg_wr, .reg_rd,
    .reg_wdata, .reg_rdata_ff, .alu_req_ff, .alu_op_ff, .alu_index_ff, .alu_wdata_ff,
    .alu_srch_ready_ff, .alu_ack, .alu_rdata, .alu_entry_valid, .alu_srch_done, .alu_count);
`default_nettype wire

// ---- rtl/swa_access_ctrl.sv ----
// switch address table access controller: register bank, lookup port, fixed tables
// Operation
// R1: after a search the valid-entry count shows in bits 29:16
// R2: lookup go bit set by software, held while busy, self-clears when done
// R3: entry-ready bit 6 sets per found entry, clears on reading byte 0x042F
// R4: bit 5 reads high when an entry is ready or the search ended
// R5: bit 2 picks direct indexing (debug) or hashed indexing
// R6: operation field 00 none, 01 write, 10 read, 11 search
// R7: slot field 21:16 indexes multicast fully, static table with 19:16
// R8: fixed-table go bit 7 self-clears once the access finishes
// R9: bit 1 selects multicast table (1) or static table (0)
// R10: bit 0 selects read (1) or write (0) on the fixed table
// R11: four entry words carry write data and read results
// R12: multicast accesses use entry word two only
// R13: lookup index from index registers, content from entry words
// R14: filter identifier bits 22:16 plus 48-bit MAC are hashed
// R15: direct mode uses lower MAC index bits 11:0 as entry index
// R16: software waits for go to clear before a new start
`timescale 1ns/100ps
`default_nettype none

module swa_access_ctrl (
    // clock and reset
    input  wire logic                          clk_sys,
    input  wire logic                          nrst,
    // byte-wide register port from the management interface
    input  wire logic [15:0]                   reg_addr,
    input  wire logic                          reg_wr,
    input  wire logic                          reg_rd,
    input  wire logic [7:0]                    reg_wdata,
    output logic      [7:0]                    reg_rdata_ff,
    // address lookup engine port
    output logic                               alu_req_ff,
    output logic      [1:0]                    alu_op_ff,
    output logic      [swa_pkg::INDEX_W-1:0]   alu_index_ff,
    output logic      [swa_pkg::ENTRY_W-1:0]   alu_wdata_ff,
    output logic                               alu_srch_ready_ff,
    input  wire logic                          alu_ack,
    input  wire logic [swa_pkg::ENTRY_W-1:0]   alu_rdata,
    input  wire logic                          alu_entry_valid,
    input  wire logic                          alu_srch_done,
    input  wire logic [swa_pkg::COUNT_W-1:0]   alu_count
);

    // ************************************************************
    // state
    // ************************************************************
    swa_pkg::swa_state_t                 state_ff,   nxt_state;
    logic [15:0]                         mac_hi_ff,  nxt_mac_hi;
    logic [31:0]                         mac_lo_ff,  nxt_mac_lo;
    logic [swa_pkg::FILT_ID_W-1:0]       filt_id_ff, nxt_filt_id;
    logic                                idx_rsv_ff, nxt_idx_rsv;
    logic                                alu_go_ff,  nxt_alu_go;
    logic                                valid_ff,   nxt_valid;
    logic                                end_ff,     nxt_end;
    logic                                direct_ff,  nxt_direct;
    logic [1:0]                          act_ff,     nxt_act;
    logic [1:0]                          alu_rsv_ff, nxt_alu_rsv;
    logic [swa_pkg::COUNT_W-1:0]         count_ff,   nxt_count;
    logic                                fix_go_ff,  nxt_fix_go;
    logic                                fix_ph_ff,  nxt_fix_ph;
    logic                                fix_sel_ff, nxt_fix_sel;
    logic                                fix_rd_ff,  nxt_fix_rd;
    logic [4:0]                          fix_rsv_ff, nxt_fix_rsv;
    logic [swa_pkg::SLOT_W-1:0]          slot_ff,    nxt_slot;
    logic [3:0][swa_pkg::WORD_W-1:0]     entry_ff,   nxt_entry;
    logic [7:0]                          nxt_rdata;
    logic                                nxt_req;
    logic [1:0]                          nxt_op;
    logic [swa_pkg::INDEX_W-1:0]         nxt_index;
    logic [swa_pkg::ENTRY_W-1:0]         nxt_wdata;
    logic                                nxt_srdy;
    logic                                st_we;
    logic                                mc_we;
    logic [swa_pkg::ENTRY_W-1:0]         st_rdata;
    logic [swa_pkg::WORD_W-1:0]          mc_rdata;
    logic [31:0]                         rd_word;

    // ************************************************************
    // lookup index
    // ************************************************************
    // fold key into 12 bits; the real hash sits in the lookup engine, this only seeds it
    function automatic logic [swa_pkg::INDEX_W-1:0] hash_index(
        input logic [47:0]                   mac,
        input logic [swa_pkg::FILT_ID_W-1:0] filt_id
    );
        hash_index = mac[11:0] ^ mac[23:12] ^ mac[35:24] ^ mac[47:36] ^ {5'h00, filt_id};
    endfunction

    // ************************************************************
    // fixed tables
    // ************************************************************
    swa_fixed_table #(
        .AW (swa_pkg::STATIC_AW),
        .DW (swa_pkg::ENTRY_W)
    ) u_static_table (
        .clk_sys  (clk_sys),
        .nrst     (nrst),
        .wr_en    (st_we),
        .addr     (slot_ff[swa_pkg::STATIC_AW-1:0]),
        .wdata    (entry_ff),
        .rdata_ff (st_rdata)
    );

    swa_fixed_table #(
        .AW (swa_pkg::MC_AW),
        .DW (swa_pkg::WORD_W)
    ) u_mcast_table (
        .clk_sys  (clk_sys),
        .nrst     (nrst),
        .wr_en    (mc_we),
        .addr     (slot_ff),
        .wdata    (entry_ff[swa_pkg::MC_WORD]),
        .rdata_ff (mc_rdata)
    );

    // ************************************************************
    // register read mux
    // ************************************************************
    // word view of each register, byte picked by the low address bits
    always_comb begin
        unique case ({reg_addr[15:2], 2'b00})
            swa_pkg::ADDR_INDEX_0:     rd_word = {idx_rsv_ff, 8'h00, filt_id_ff, mac_hi_ff};
            swa_pkg::ADDR_INDEX_1:     rd_word = mac_lo_ff;
            // R1: count field
            // R4: ready or ended
            swa_pkg::ADDR_LOOKUP_CTRL: rd_word = {2'b00, count_ff, 8'h00, alu_go_ff, valid_ff,
                                                  valid_ff | (end_ff & ~alu_go_ff), alu_rsv_ff,
                                                  direct_ff, act_ff};
            swa_pkg::ADDR_FIXED_CTRL:  rd_word = {10'h000, slot_ff, 8'h00, fix_go_ff, fix_rsv_ff,
                                                  fix_sel_ff, fix_rd_ff};
            swa_pkg::ADDR_ENTRY_1:     rd_word = entry_ff[0];
            swa_pkg::ADDR_ENTRY_2:     rd_word = entry_ff[1];
            swa_pkg::ADDR_ENTRY_3:     rd_word = entry_ff[2];
            swa_pkg::ADDR_ENTRY_4:     rd_word = entry_ff[3];
            default:                   rd_word = swa_pkg::RST_WORD;
        endcase
        nxt_rdata = rd_word[{reg_addr[1:0], 3'b000} +: 8];
    end

    // ************************************************************
    // register writes, lookup sequencing, fixed-table sequencing
    // ************************************************************
    always_comb begin
        nxt_state   = state_ff;
        nxt_mac_hi  = mac_hi_ff;
        nxt_mac_lo  = mac_lo_ff;
        nxt_filt_id = filt_id_ff;
        nxt_idx_rsv = idx_rsv_ff;
        nxt_alu_go  = alu_go_ff;
        nxt_valid   = valid_ff;
        nxt_end     = end_ff;
        nxt_direct  = direct_ff;
        nxt_act     = act_ff;
        nxt_alu_rsv = alu_rsv_ff;
        nxt_count   = count_ff;
        nxt_fix_go  = fix_go_ff;
        nxt_fix_ph  = fix_ph_ff;
        nxt_fix_sel = fix_sel_ff;
        nxt_fix_rd  = fix_rd_ff;
        nxt_fix_rsv = fix_rsv_ff;
        nxt_slot    = slot_ff;
        nxt_entry   = entry_ff;
        nxt_req     = alu_req_ff;
        nxt_op      = alu_op_ff;
        nxt_index   = alu_index_ff;
        nxt_wdata   = alu_wdata_ff;
        st_we       = 1'b0;
        mc_we       = 1'b0;

        // software writes; control fields freeze while their access runs
        if (reg_wr) begin
            unique case (reg_addr)
                16'h0410: nxt_mac_hi[7:0]  = reg_wdata;
                16'h0411: nxt_mac_hi[15:8] = reg_wdata;
                16'h0412: nxt_filt_id      = reg_wdata[swa_pkg::FILT_ID_W-1:0];
                16'h0413: nxt_idx_rsv      = reg_wdata[7];
                16'h0414: nxt_mac_lo[7:0]   = reg_wdata;
                16'h0415: nxt_mac_lo[15:8]  = reg_wdata;
                16'h0416: nxt_mac_lo[23:16] = reg_wdata;
                16'h0417: nxt_mac_lo[31:24] = reg_wdata;
                swa_pkg::ADDR_LOOKUP_CTRL: begin
                    if (!alu_go_ff) begin
                        // R5: index mode
                        nxt_direct  = reg_wdata[swa_pkg::DIRECT_BIT];
                        nxt_act     = reg_wdata[1:0];
                        nxt_alu_rsv = reg_wdata[4:3];
                        // R2: start on one
                        nxt_alu_go  = reg_wdata[swa_pkg::GO_BIT];
                    end
                end
                swa_pkg::ADDR_FIXED_CTRL: begin
                    if (!fix_go_ff) begin
                        // R9: table select
                        nxt_fix_sel = reg_wdata[swa_pkg::FIX_SEL_BIT];
                        // R10: read or write
                        nxt_fix_rd  = reg_wdata[swa_pkg::FIX_RD_BIT];
                        nxt_fix_rsv = reg_wdata[6:2];
                        nxt_fix_go  = reg_wdata[swa_pkg::GO_BIT];
                    end
                end
                16'h041E: begin
                    if (!fix_go_ff) begin
                        nxt_slot = reg_wdata[swa_pkg::SLOT_W-1:0];
                    end
                end
                default: begin
                    // R11: shared entry words
                    if (reg_addr[15:4] == swa_pkg::ADDR_ENTRY_1[15:4]) begin
                        nxt_entry[reg_addr[3:2]][{reg_addr[1:0], 3'b000} +: 8] = reg_wdata;
                    end
                end
            endcase
        end

        // R3: top byte read drops ready
        if (reg_rd && reg_addr == swa_pkg::ADDR_ENTRY_4_TOP) begin
            nxt_valid = 1'b0;
        end

        // lookup engine sequencing
        unique case (state_ff)
            swa_pkg::SWA_ST_IDLE: begin
                if (alu_go_ff) begin
                    // R6: operation decode
                    if (swa_pkg::swa_act_t'(act_ff) == swa_pkg::SWA_ACT_NOP) begin
                        nxt_alu_go = 1'b0;
                    end else begin
                        nxt_req   = 1'b1;
                        nxt_op    = act_ff;
                        // R13: index and content
                        nxt_wdata = entry_ff;
                        // R15: direct index
                        // R14: hashed key
                        nxt_index = direct_ff ? mac_lo_ff[swa_pkg::INDEX_W-1:0]
                                              : hash_index({mac_hi_ff, mac_lo_ff}, filt_id_ff);
                        if (swa_pkg::swa_act_t'(act_ff) == swa_pkg::SWA_ACT_SEARCH) begin
                            nxt_state = swa_pkg::SWA_ST_SRCH;
                            nxt_end   = 1'b0;
                            nxt_valid = 1'b0;
                        end else begin
                            nxt_state = swa_pkg::SWA_ST_WAIT;
                        end
                    end
                end
            end
            swa_pkg::SWA_ST_WAIT: begin
                if (alu_ack) begin
                    nxt_req = 1'b0;
                    if (swa_pkg::swa_act_t'(alu_op_ff) == swa_pkg::SWA_ACT_READ) begin
                        nxt_entry = alu_rdata;
                    end
                    // R2: self-clear on completion
                    nxt_alu_go = 1'b0;
                    nxt_state  = swa_pkg::SWA_ST_IDLE;
                end
            end
            swa_pkg::SWA_ST_SRCH: begin
                if (alu_ack) begin
                    nxt_req = 1'b0;
                end
                // R3: next entry ready, set beats clear
                if (alu_entry_valid && alu_srch_ready_ff) begin
                    nxt_entry = alu_rdata;
                    nxt_valid = 1'b1;
                end
                if (alu_srch_done) begin
                    // R1: capture count
                    nxt_count  = alu_count;
                    nxt_end    = 1'b1;
                    nxt_req    = 1'b0;
                    nxt_alu_go = 1'b0;
                    nxt_state  = swa_pkg::SWA_ST_IDLE;
                end
            end
            default: nxt_state = swa_pkg::SWA_ST_IDLE;
        endcase

        // engine may only push a new entry once software took the last one
        nxt_srdy = (nxt_state == swa_pkg::SWA_ST_SRCH) && !nxt_valid;

        // fixed tables: issue cycle then capture cycle
        if (fix_go_ff) begin
            if (!fix_ph_ff) begin
                // R7: slot width per table
                st_we      = !fix_rd_ff && !fix_sel_ff;
                mc_we      = !fix_rd_ff && fix_sel_ff;
                nxt_fix_ph = 1'b1;
            end else begin
                if (fix_rd_ff) begin
                    // R12: multicast uses word two only
                    if (fix_sel_ff) begin
                        nxt_entry[swa_pkg::MC_WORD] = mc_rdata;
                    end else begin
                        nxt_entry = st_rdata;
                    end
                end
                // R8: self-clear when finished
                nxt_fix_go = 1'b0;
                nxt_fix_ph = 1'b0;
            end
        end
    end

    // ************************************************************
    // registers
    // ************************************************************
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            state_ff          <= swa_pkg::SWA_ST_IDLE;
            mac_hi_ff         <= '0;
            mac_lo_ff         <= swa_pkg::RST_WORD;
            filt_id_ff        <= '0;
            idx_rsv_ff        <= 1'b0;
            alu_go_ff         <= 1'b0;
            valid_ff          <= 1'b0;
            end_ff            <= 1'b0;
            direct_ff         <= 1'b0;
            act_ff            <= 2'h0;
            alu_rsv_ff        <= 2'h0;
            count_ff          <= swa_pkg::RST_COUNT;
            fix_go_ff         <= 1'b0;
            fix_ph_ff         <= 1'b0;
            fix_sel_ff        <= 1'b0;
            fix_rd_ff         <= 1'b0;
            fix_rsv_ff        <= 5'h00;
            slot_ff           <= '0;
            entry_ff          <= '0;
            reg_rdata_ff      <= swa_pkg::RST_BYTE;
            alu_req_ff        <= 1'b0;
            alu_op_ff         <= 2'h0;
            alu_index_ff      <= '0;
            alu_wdata_ff      <= '0;
            alu_srch_ready_ff <= 1'b0;
        end else begin
            state_ff          <= nxt_state;
            mac_hi_ff         <= nxt_mac_hi;
            mac_lo_ff         <= nxt_mac_lo;
            filt_id_ff        <= nxt_filt_id;
            idx_rsv_ff        <= nxt_idx_rsv;
            alu_go_ff         <= nxt_alu_go;
            valid_ff          <= nxt_valid;
            end_ff            <= nxt_end;
            direct_ff         <= nxt_direct;
            act_ff            <= nxt_act;
            alu_rsv_ff        <= nxt_alu_rsv;
            count_ff          <= nxt_count;
            fix_go_ff         <= nxt_fix_go;
            fix_ph_ff         <= nxt_fix_ph;
            fix_sel_ff        <= nxt_fix_sel;
            fix_rd_ff         <= nxt_fix_rd;
            fix_rsv_ff        <= nxt_fix_rsv;
            slot_ff           <= nxt_slot;
            entry_ff          <= nxt_entry;
            reg_rdata_ff      <= nxt_rdata;
            alu_req_ff        <= nxt_req;
            alu_op_ff         <= nxt_op;
            alu_index_ff      <= nxt_index;
            alu_wdata_ff      <= nxt_wdata;
            alu_srch_ready_ff <= nxt_srdy;
        end
    end

endmodule
`default_nettype wire

// ---- rtl/swa_fixed_table.sv ----
// flip-flop table with one write port and a registered read port
`timescale 1ns/100ps
`default_nettype none

module swa_fixed_table #(
    parameter int AW = 4,
    parameter int DW = 128
) (
    // clock and reset
    input  wire logic          clk_sys,
    input  wire logic          nrst,
    // access port
    input  wire logic          wr_en,
    input  wire logic [AW-1:0] addr,
    input  wire logic [DW-1:0] wdata,
    output logic      [DW-1:0] rdata_ff
);

    logic [DW-1:0] mem_ff     [2**AW];
    logic [DW-1:0] nxt_mem    [2**AW];
    logic [DW-1:0] nxt_rdata;

    // write one slot, read the addressed slot every cycle
    always_comb begin
        nxt_mem = mem_ff;
        if (wr_en) begin
            nxt_mem[addr] = wdata;
        end
        nxt_rdata = mem_ff[addr];
    end

    // storage clears at reset so a read before any write is defined
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            for (int i = 0; i < 2**AW; i++) begin
                mem_ff[i] <= '0;
            end
            rdata_ff <= '0;
        end else begin
            mem_ff   <= nxt_mem;
            rdata_ff <= nxt_rdata;
        end
    end

endmodule
`default_nettype wire

// ---- rtl/swa_pkg.sv ----
// constants and types shared by the switch address table access block
package swa_pkg;

    // ************************************************************
    // register byte addresses
    // ************************************************************
    localparam logic [15:0] ADDR_INDEX_0     = 16'h0410;
    localparam logic [15:0] ADDR_INDEX_1     = 16'h0414;
    localparam logic [15:0] ADDR_LOOKUP_CTRL = 16'h0418;
    localparam logic [15:0] ADDR_FIXED_CTRL  = 16'h041C;
    localparam logic [15:0] ADDR_ENTRY_1     = 16'h0420;
    localparam logic [15:0] ADDR_ENTRY_2     = 16'h0424;
    localparam logic [15:0] ADDR_ENTRY_3     = 16'h0428;
    localparam logic [15:0] ADDR_ENTRY_4     = 16'h042C;
    localparam logic [15:0] ADDR_ENTRY_4_TOP = 16'h042F;

    // ************************************************************
    // field positions and widths
    // ************************************************************
    localparam int GO_BIT        = 7;
    localparam int VALID_BIT     = 6;
    localparam int READY_END_BIT = 5;
    localparam int DIRECT_BIT    = 2;
    localparam int FIX_SEL_BIT   = 1;
    localparam int FIX_RD_BIT    = 0;
    localparam int COUNT_LSB     = 16;
    localparam int COUNT_W       = 14;
    localparam int FILT_ID_LSB   = 16;
    localparam int FILT_ID_W     = 7;
    localparam int SLOT_LSB      = 16;
    localparam int SLOT_W        = 6;
    localparam int INDEX_W       = 12;
    localparam int WORD_W        = 32;
    localparam int ENTRY_WORDS   = 4;
    localparam int ENTRY_W       = WORD_W * ENTRY_WORDS;
    localparam int MC_WORD       = 1;
    localparam int STATIC_AW     = 4;
    localparam int MC_AW         = 6;

    // ************************************************************
    // reset values
    // ************************************************************
    localparam logic [WORD_W-1:0]  RST_WORD  = 32'h0000_0000;
    localparam logic [7:0]         RST_BYTE  = 8'h00;
    localparam logic [COUNT_W-1:0] RST_COUNT = 14'h0000;

    // ************************************************************
    // lookup operations and controller states
    // ************************************************************
    typedef enum logic [1:0] {
        SWA_ACT_NOP    = 2'b00,
        SWA_ACT_WRITE  = 2'b01,
        SWA_ACT_READ   = 2'b10,
        SWA_ACT_SEARCH = 2'b11
    } swa_act_t;

    typedef enum logic [1:0] {
        SWA_ST_IDLE = 2'b00,
        SWA_ST_WAIT = 2'b01,
        SWA_ST_SRCH = 2'b10
    } swa_state_t;

endpackage
